// >>> rtl/adc_slave_serial_readout.sv
// Slave serial readout port of a 16-bit sampling converter.
// Assumes the host drives the serial clock; all pins are sampled on clk_sys.
// Operation
// - Clock source select high means the host supplies the serial clock.
// - Serial clock is gated by chip select; data driven only with read enable low.
// - Continuous or burst clock accepted, idling high or low.
// - After busy falls, the new result is presented when selected and read.
// - Result leaves MSB first over 16 clock pulses, stable across both edges.
// - Read-after-conversion clock may run up to the maximum rate; the port here follows only clocks below half the 20 MHz clk_sys.
// - Chain input cascades converters only in read-after-conversion mode.
// - Chain input sampled on the edge opposite the shift edge.
// - During conversion, previous result is read MSB first over 16 pulses.
// - Read during conversion still incomplete when busy falls pulses the read error output.
// - Output is high impedance while chip select or read enable is high.
// - Serial port works only while serial select is high.
// - Conversion start falling edge begins conversion; busy high until done.
// - Output coding select picks two's complement or straight binary.
`timescale 1ns/10ps
module adc_slave_serial_readout
	import adc_serial_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic conversion_start_n,
	input wire logic chip_select_n,
	input wire logic read_enable_n,
	input wire logic serial_clock,
	input wire logic chain_data_in,
	input wire logic clock_source_select,
	input wire logic serial_parallel_select,
	input wire logic output_coding_select,
	input wire logic [15:0] sample_code,
	output logic serial_data_out,
	output logic serial_data_out_oe,
	output logic busy,
	output logic read_error
);

	logic [SYNC_WIDTH-1:0] pins_s;
	logic conv_start_n_s;
	logic cs_n_s;
	logic rd_n_s;
	logic sclk_s;
	logic chain_s;
	logic ext_s;
	logic ser_s;
	logic coding_s;
	logic conv_done;
	logic [15:0] result;
	logic [15:0] load_word;

	frame_state_type state_q;
	logic [3:0] bit_cnt_q;
	logic [15:0] shift_q;
	logic sclk_prev_q;
	logic armed_q;
	logic chain_q;
	logic during_conv_q;
	logic oe_q;
	logic err_q;

	logic port_on;
	logic cs_active;
	logic read_on;
	logic sclk_rise;
	logic sclk_fall;
	logic shift_now;

	pin_sync u_pin_sync (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.pins_async({conversion_start_n, chip_select_n, read_enable_n, serial_clock,
			chain_data_in, clock_source_select, serial_parallel_select,
			output_coding_select}),
		.pins_sync(pins_s)
	);

	assign conv_start_n_s = pins_s[PIN_CONV_START];
	assign cs_n_s = pins_s[PIN_CHIP_SELECT];
	assign rd_n_s = pins_s[PIN_READ_ENABLE];
	assign sclk_s = pins_s[PIN_SCLK];
	assign chain_s = pins_s[PIN_CHAIN];
	assign ext_s = pins_s[PIN_CLK_SOURCE];
	assign ser_s = pins_s[PIN_SERIAL_PARALLEL_SELECT];
	assign coding_s = pins_s[PIN_CODING];

	conv_timer u_conv_timer (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.start_n(conv_start_n_s),
		.sample_code(sample_code),
		.busy(busy),
		.conv_done(conv_done),
		.result(result)
	);

	// Internal-clock mode is not built, so the port stays quiet then
	assign port_on = ser_s & ext_s;
	assign cs_active = port_on & ~cs_n_s;
	assign read_on = cs_active & ~rd_n_s;
	assign load_word = apply_coding(result, coding_s);

	// Edges of the host clock, seen only while selected
	assign sclk_rise = cs_active & sclk_s & ~sclk_prev_q;
	assign sclk_fall = cs_active & ~sclk_s & sclk_prev_q;
	// A falling edge before any rising one is the idle-high lead-in
	assign shift_now = sclk_fall & armed_q;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sclk_prev_q <= 1'b0;
		end else begin
			sclk_prev_q <= sclk_s;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_q <= FRAME_IDLE;
			bit_cnt_q <= 4'h0;
			during_conv_q <= 1'b0;
		end else begin
			case (state_q)
				FRAME_IDLE: begin
					if (read_on) begin
						state_q <= FRAME_OWN;
						bit_cnt_q <= 4'h0;
						during_conv_q <= busy;
					end
				end
				FRAME_OWN: begin
					if (!cs_active) begin
						state_q <= FRAME_IDLE;
					end else if (shift_now) begin
						bit_cnt_q <= bit_cnt_q + 4'h1;
						if (bit_cnt_q == LAST_BIT) begin
							state_q <= FRAME_CHAIN;
						end
					end
				end
				FRAME_CHAIN: begin
					if (!cs_active) begin
						state_q <= FRAME_IDLE;
					end
				end
				default: begin
					state_q <= FRAME_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			armed_q <= 1'b0;
		end else if (state_q == FRAME_IDLE) begin
			armed_q <= 1'b0;
		end else if (sclk_rise) begin
			armed_q <= 1'b1;
		end
	end

	// Chain bit taken on the rising edge, opposite the shifting fall
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			chain_q <= 1'b0;
		end else if (state_q == FRAME_IDLE) begin
			chain_q <= 1'b0;
		end else if (sclk_rise && !during_conv_q) begin
			chain_q <= chain_s;
		end
	end

	// Idle reloads the latest result so every read begins at its MSB
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			shift_q <= RESULT_RESET;
		end else if (state_q == FRAME_IDLE) begin
			shift_q <= load_word;
		end else if (shift_now) begin
			shift_q <= {shift_q[MSB_POS-1:0], chain_q};
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			oe_q <= 1'b0;
		end else begin
			oe_q <= read_on;
		end
	end

	// Conversion finished before all own bits of a during-conversion read
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			err_q <= 1'b0;
		end else begin
			err_q <= conv_done & during_conv_q & (state_q == FRAME_OWN);
		end
	end

	assign serial_data_out = shift_q[MSB_POS];
	assign serial_data_out_oe = oe_q;
	assign read_error = err_q;

	property p_hiz_when_idle;
		@(posedge clk_sys) disable iff (!resetn)
		(cs_n_s || rd_n_s) |=> !serial_data_out_oe;
	endproperty
	a_hiz_when_idle: assert property (p_hiz_when_idle) else $error("output driven while deselected");

	property p_parallel_quiet;
		@(posedge clk_sys) disable iff (!resetn)
		(!ser_s || !ext_s) |=> (!serial_data_out_oe && state_q == FRAME_IDLE);
	endproperty
	a_parallel_quiet: assert property (p_parallel_quiet) else $error("port active outside mode");

	property p_msb_loaded;
		@(posedge clk_sys) disable iff (!resetn)
		(state_q == FRAME_IDLE && read_on) |=> shift_q == $past(load_word);
	endproperty
	a_msb_loaded: assert property (p_msb_loaded) else $error("read did not start at result");

	property p_shift_step;
		@(posedge clk_sys) disable iff (!resetn)
		(state_q != FRAME_IDLE && shift_now)
			|=> shift_q == {$past(shift_q[MSB_POS-1:0]), $past(chain_q)};
	endproperty
	a_shift_step: assert property (p_shift_step) else $error("shift step wrong");

	property p_hold_between_edges;
		@(posedge clk_sys) disable iff (!resetn)
		(state_q != FRAME_IDLE && !shift_now && cs_active) |=> $stable(serial_data_out);
	endproperty
	a_hold_between_edges: assert property (p_hold_between_edges) else $error("data moved off edge");

	property p_sixteen_bits;
		@(posedge clk_sys) disable iff (!resetn)
		(state_q == FRAME_OWN && shift_now && cs_active && bit_cnt_q == LAST_BIT)
			|=> state_q == FRAME_CHAIN;
	endproperty
	a_sixteen_bits: assert property (p_sixteen_bits) else $error("frame not 16 bits");

	property p_no_chain_in_conv;
		@(posedge clk_sys) disable iff (!resetn)
		(state_q != FRAME_IDLE && during_conv_q) |-> !chain_q;
	endproperty
	a_no_chain_in_conv: assert property (p_no_chain_in_conv) else $error("chain used in conv read");

	property p_error_cause;
		@(posedge clk_sys) disable iff (!resetn)
		(conv_done && during_conv_q && state_q == FRAME_OWN) |=> read_error ##1 !read_error;
	endproperty
	a_error_cause: assert property (p_error_cause) else $error("read error not pulsed");

	property p_error_only_on_done;
		@(posedge clk_sys) disable iff (!resetn)
		read_error |-> $past(conv_done);
	endproperty
	a_error_only_on_done: assert property (p_error_only_on_done) else $error("spurious read error");

	c_chain_reached: cover property (@(posedge clk_sys) disable iff (!resetn)
		state_q == FRAME_CHAIN && shift_now);
	c_read_during_conv: cover property (@(posedge clk_sys) disable iff (!resetn)
		state_q == FRAME_OWN && during_conv_q && shift_now);
	c_read_error: cover property (@(posedge clk_sys) disable iff (!resetn) read_error);

	property p_oe_follows_read;
		@(posedge clk_sys) disable iff (!resetn)
		read_on |=> serial_data_out_oe;
	endproperty
	a_oe_follows_read: assert property (p_oe_follows_read) else $error("read not driven");

	property p_chain_capture;
		@(posedge clk_sys) disable iff (!resetn)
		(state_q != FRAME_IDLE && sclk_rise && !during_conv_q) |=> chain_q == $past(chain_s);
	endproperty
	a_chain_capture: assert property (p_chain_capture) else $error("chain not taken");

	property p_during_flag;
		@(posedge clk_sys) disable iff (!resetn)
		(state_q == FRAME_IDLE && read_on) |=> during_conv_q == $past(busy);
	endproperty
	a_during_flag: assert property (p_during_flag) else $error("read kind lost");

	property p_error_one_cycle;
		@(posedge clk_sys) disable iff (!resetn)
		read_error |=> !read_error;
	endproperty
	a_error_one_cycle: assert property (p_error_one_cycle) else $error("error too long");

	c_lead_in_ignored: cover property (@(posedge clk_sys) disable iff (!resetn)
		state_q == FRAME_OWN && sclk_fall && !armed_q);

endmodule

// >>> rtl/adc_serial_pkg.sv
// Shared constants and types for the slave serial readout port.
// Assumes a single 20 MHz system clock; all pin timing is sampled on it.
package adc_serial_pkg;

	localparam int RESULT_WIDTH = 16;
	localparam int MSB_POS = 15;
	localparam logic [15:0] RESULT_RESET = 16'h0000;
	localparam logic [3:0] LAST_BIT = 4'hf;

	// Pin synchroniser layout
	localparam int SYNC_WIDTH = 8;
	localparam logic [7:0] SYNC_RESET = 8'hff;
	localparam int PIN_CONV_START = 7;
	localparam int PIN_CHIP_SELECT = 6;
	localparam int PIN_READ_ENABLE = 5;
	localparam int PIN_SCLK = 4;
	localparam int PIN_CHAIN = 3;
	localparam int PIN_CLK_SOURCE = 2;
	localparam int PIN_SERIAL_PARALLEL_SELECT = 1;
	localparam int PIN_CODING = 0;

	// Timing
	localparam int CLK_SYS_KHZ = 20000;
	localparam int CONV_TIME_NS = 7000;
	localparam int CONV_CYCLES_RAW = (CONV_TIME_NS * CLK_SYS_KHZ) / 1000000;
	localparam int CONV_CYCLES = (CONV_CYCLES_RAW < 1) ? 1 : CONV_CYCLES_RAW;
	localparam int CONV_CNT_WIDTH = 8;
	localparam logic [7:0] CONV_LAST = 8'(CONV_CYCLES - 1);
	localparam logic [7:0] CONV_CNT_RESET = 8'h00;
	localparam int SCLK_MAX_KHZ = 40000;
	localparam int SCLK_RDC_MIN_KHZ = 18000;

	typedef enum logic [2:0] {
		FRAME_IDLE = 3'b001,
		FRAME_OWN = 3'b010,
		FRAME_CHAIN = 3'b100
	} frame_state_type;

	// Straight binary when select is high, two's complement otherwise
	function automatic logic [15:0] apply_coding(input logic [15:0] raw, input logic straight);
		apply_coding = straight ? raw : {~raw[MSB_POS], raw[MSB_POS-1:0]};
	endfunction

endpackage

// >>> rtl/pin_sync.sv
// Two-flop synchroniser for the asynchronous control and clock pins.
// Assumes pins are quasi-static or slower than half the system clock.
`timescale 1ns/10ps
module pin_sync
	import adc_serial_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [SYNC_WIDTH-1:0] pins_async,
	output logic [SYNC_WIDTH-1:0] pins_sync
);

	logic [SYNC_WIDTH-1:0] stage1_q;
	logic [SYNC_WIDTH-1:0] stage2_q;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			stage1_q <= SYNC_RESET;
			stage2_q <= SYNC_RESET;
		end else begin
			stage1_q <= pins_async;
			stage2_q <= stage1_q;
		end
	end

	assign pins_sync = stage2_q;

endmodule

// >>> rtl/conv_timer.sv
// Conversion sequencer: busy window and result capture.
// Assumes the converter core presents a stable code at the end of busy.
`timescale 1ns/10ps
module conv_timer
	import adc_serial_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic start_n,
	input wire logic [15:0] sample_code,
	output logic busy,
	output logic conv_done,
	output logic [15:0] result
);

	logic start_prev_q;
	logic busy_q;
	logic done_q;
	logic [CONV_CNT_WIDTH-1:0] cnt_q;
	logic [15:0] result_q;
	logic start_fall;

	assign start_fall = start_prev_q & ~start_n;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			start_prev_q <= 1'b1;
		end else begin
			start_prev_q <= start_n;
		end
	end

	// Running conversion cannot be restarted
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			busy_q <= 1'b0;
			cnt_q <= CONV_CNT_RESET;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (!busy_q) begin
				if (start_fall) begin
					busy_q <= 1'b1;
					cnt_q <= CONV_CNT_RESET;
				end
			end else if (cnt_q == CONV_LAST) begin
				busy_q <= 1'b0;
				done_q <= 1'b1;
			end else begin
				cnt_q <= cnt_q + 8'h01;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			result_q <= RESULT_RESET;
		end else if (busy_q && cnt_q == CONV_LAST) begin
			result_q <= sample_code;
		end
	end

	assign busy = busy_q;
	assign conv_done = done_q;
	assign result = result_q;

	property p_start_busy;
		@(posedge clk_sys) disable iff (!resetn)
		(start_fall && !busy_q) |=> busy_q;
	endproperty
	a_start_busy: assert property (p_start_busy) else $error("busy did not rise on start");

	property p_done_ends_busy;
		@(posedge clk_sys) disable iff (!resetn)
		$fell(busy_q) |-> done_q ##1 !done_q;
	endproperty
	a_done_ends_busy: assert property (p_done_ends_busy) else $error("done not tied to busy fall");

endmodule

// >>> verification/serial_host_model.sv
// Host serial master model: drives select, read enable, serial clock, chain input.
// Assumes the bench calls read_frame; all changes follow rising edges of clk_sys.
`timescale 1ns/10ps
module serial_host_model (
	input wire logic clk_sys,
	input wire logic serial_data_out,
	input wire logic serial_data_out_oe,
	output logic chip_select_n,
	output logic read_enable_n,
	output logic serial_clock,
	output logic chain_data_in
);
	initial begin
		chip_select_n = 1'b1;
		read_enable_n = 1'b1;
		serial_clock = 1'b0;
		chain_data_in = 1'b0;
	end

	// One half period of the link clock: 200 ns is four system cycles
	task automatic half(input logic lvl, inout logic seen);
		serial_clock <= lvl;
		repeat (4) begin
			@(posedge clk_sys);
			seen = seen | (serial_data_out_oe === 1'b1);
		end
	endtask

	task automatic read_frame(input int nbits, input logic idle_high, input logic chain_run,
		input logic [15:0] up_word, input int hold, output logic [31:0] data,
		output logic seen);
		logic [15:0] up;
		up = up_word;
		data = 32'h0;
		seen = 1'b0;
		chain_data_in <= up[15];
		serial_clock <= idle_high;
		chip_select_n <= 1'b0;
		read_enable_n <= 1'b0;
		repeat (5) @(posedge clk_sys);
		if (idle_high) half(1'b0, seen);
		for (int i = 0; i < nbits; i++) begin
			half(1'b1, seen);
			data = {data[30:0], serial_data_out};
			if (chain_run) begin
				up = {up[14:0], 1'b0};
				chain_data_in <= up[15];
			end
			half(1'b0, seen);
		end
		if (idle_high) half(1'b1, seen);
		repeat (hold) @(posedge clk_sys);
		chip_select_n <= 1'b1;
		read_enable_n <= 1'b1;
		// Released line: show the inverse rather than a stale level
		chain_data_in <= ~chain_data_in;
		repeat (5) @(posedge clk_sys);
	endtask
endmodule

// >>> verification/adc_slave_serial_readout_tb.sv
// Self-checking bench for the slave serial readout port.
// Assumes the host model for all serial traffic; 20 MHz system clock.
`timescale 1ns/10ps
module adc_slave_serial_readout_tb
	import adc_serial_pkg::*;
();
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic conversion_start_n = 1'b1;
	logic clock_source_select = 1'b1;
	logic serial_parallel_select = 1'b1;
	logic output_coding_select = 1'b1;
	logic [15:0] sample_code = 16'h0000;
	logic chip_select_n;
	logic read_enable_n;
	logic serial_clock;
	logic chain_data_in;
	logic serial_data_out;
	logic serial_data_out_oe;
	logic busy;
	logic read_error;
	int fail_count = 0;
	int n_checks = 0;
	int err_cycles = 0;
	int width;
	logic [31:0] word;
	logic seen;

	adc_slave_serial_readout DUT (.clk_sys(clk_sys), .resetn(resetn),
		.conversion_start_n(conversion_start_n), .chip_select_n(chip_select_n),
		.read_enable_n(read_enable_n), .serial_clock(serial_clock),
		.chain_data_in(chain_data_in), .clock_source_select(clock_source_select),
		.serial_parallel_select(serial_parallel_select),
		.output_coding_select(output_coding_select), .sample_code(sample_code),
		.serial_data_out(serial_data_out), .serial_data_out_oe(serial_data_out_oe),
		.busy(busy), .read_error(read_error));

	serial_host_model host (.clk_sys(clk_sys), .serial_data_out(serial_data_out),
		.serial_data_out_oe(serial_data_out_oe), .chip_select_n(chip_select_n),
		.read_enable_n(read_enable_n), .serial_clock(serial_clock),
		.chain_data_in(chain_data_in));

	always #25 clk_sys = ~clk_sys;

	always @(posedge clk_sys) begin
		if (read_error === 1'b1) err_cycles++;
	end

	function automatic logic [31:0] coded(input logic [15:0] raw, input logic straight);
		coded = {16'h0000, straight ? raw : {~raw[15], raw[14:0]}};
	endfunction

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic end_sim();
		if (fail_count == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Start pulse, plus a second start inside busy that must be ignored
	task automatic convert(input logic [15:0] code, output int w);
		sample_code <= code;
		conversion_start_n <= 1'b0;
		w = 0;
		for (int i = 0; i < 400 && !(w > 0 && busy === 1'b0); i++) begin
			@(posedge clk_sys);
			if (busy === 1'b1) w++;
			if (i == 3 || i == 40) conversion_start_n <= 1'b1;
			if (i == 30) conversion_start_n <= 1'b0;
		end
	endtask

	task automatic wait_busy();
		for (int i = 0; i < 20 && busy !== 1'b1; i++) @(posedge clk_sys);
	endtask

	initial begin
		repeat (20000) @(posedge clk_sys);
		fail_count++;
		end_sim();
	end

	initial begin
		repeat (20) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		for (int k = 1; k >= 0; k--) begin
			output_coding_select <= k[0];
			convert(16'h9a5c, width);
			check("busy_width", 32'(CONV_CYCLES), 32'(width));
			host.read_frame(16, 1'b0, 1'b1, 16'h0000, 0, word, seen);
			check("word", coded(16'h9a5c, k[0]), word);
			check("oe_frame", 32'h1, {31'h0, seen});
			check("oe_idle", 32'h0, {31'h0, serial_data_out_oe});
		end
		host.read_frame(16, 1'b1, 1'b1, 16'h0000, 0, word, seen);
		check("idle_high", coded(16'h9a5c, 1'b0), word);
		output_coding_select <= 1'b1;
		convert(16'h3c81, width);
		host.read_frame(32, 1'b0, 1'b1, 16'hb2e7, 0, word, seen);
		check("chain", 32'h3c81b2e7, word);
		err_cycles = 0;
		fork
			convert(16'h47d2, width);
			begin
				wait_busy();
				host.read_frame(16, 1'b0, 1'b0, 16'hffff, 0, word, seen);
			end
		join
		check("during", 32'h3c81, word);
		check("no_error", 32'h0, 32'(err_cycles));
		fork
			convert(16'h1e6b, width);
			begin
				wait_busy();
				host.read_frame(4, 1'b0, 1'b0, 16'h0000, 160, word, seen);
			end
		join
		check("partial", 32'h4, word);
		check("error_pulse", 32'h1, 32'(err_cycles));
		host.read_frame(16, 1'b0, 1'b1, 16'h0000, 0, word, seen);
		check("after_error", 32'h1e6b, word);
		for (int k = 0; k < 2; k++) begin
			serial_parallel_select <= k[0];
			clock_source_select <= ~k[0];
			@(posedge clk_sys);
			host.read_frame(4, 1'b0, 1'b1, 16'h0000, 0, word, seen);
			check("oe_off_mode", 32'h0, {31'h0, seen});
		end
		end_sim();
	end
endmodule
